// ===== rtl/ddr_init_ctrl.sv
// Purpose: Drives a DDR3 DRAM through cold or warm reset, init and mode register loads.
// Assumes: Software writes the four images before starting; bank_idle from the scheduler.
// Notes:   Long counts are parameters so simulation can shorten them.
// Operation
// - Cold reset held at least 200 us
// - CKE low 10 ns before reset release
// - Wait 500 us after reset before CKE
// - Clock stable max(10 ns, 5 tCK) first
// - NOP registered before CKE rises
// - CKE stays high until init ends
// - ODT held static low during init
// - Wait tXPR after CKE before MRS
// - Load MR2, MR3, MR1, MR0, then ZQCL
// - Bank address lines select the register
// - MR1 DLL enabled, MR0 DLL reset set
// - Only NOPs between MRS and ZQCL
// - Warm reset 100 ns, then repeat
// - Write every mode register after reset
// - Each MRS drives the whole word
// - MRS commands spaced by tMRD
// - Other commands wait tMOD after MRS
// - Runtime MRS only while DRAM idle
// - ODT low around MRS until tMOD
// - MR0 reserved bits zero, WR large enough (WR is sent from the image unchecked)
//
// Local design decisions: the APB register port and the register offsets.
module ddr_init_ctrl #(
    parameter int RST_PWR_CYC_P  = ddr_init_pkg::RST_PWR_CYC,
    parameter int CKE_WAIT_CYC_P = ddr_init_pkg::CKE_WAIT_CYC
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Scheduler status
    input  wire logic              bank_idle,
    // DRAM pins
    output ddr_init_pkg::dram_pins_s dram
);
    import ddr_init_pkg::*;

    localparam int WAIT_LOAD = (CKE_WAIT_CYC_P > CK_STABLE_CYC) ? CKE_WAIT_CYC_P
                                                                : CK_STABLE_CYC;

    state_e              state_q, state_d;
    logic [CNT_W-1:0]    cnt_q, cnt_d;
    logic [1:0]          seq_q, seq_d;
    logic                done_q, done_d;
    logic                cold_q, cold_d;
    logic                refuse;
    logic                cold_go_q, warm_go_q, mrs_go_q;
    logic [1:0]          req_mr_q;
    logic                odt_lvl_q;
    logic                err_q;
    logic [31:0]         prdata_q;
    logic                pready_q, pslverr_q;
    dram_pins_s          dram_q, pin_d;
    logic [1:0]          mr_sel;
    logic [ADDR_W-1:0]   mr_word, mrs_word, rd_a;
    logic                acc, wr_acc, mr_hit, hit;
    logic [31:0]         rd_mux;
    logic                busy;

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign dram    = dram_q;
    assign busy    = !(state_q == ST_IDLE || state_q == ST_READY);

    // ==================================================================
    // Mode register images
    assign acc    = psel && penable && pready_q;
    assign wr_acc = acc && pwrite;
    assign mr_hit = paddr[11:4] == REG_MR0[11:4];
    assign mr_sel = done_q ? req_mr_q : init_mr(seq_q);

    mr_store #(.DW(ADDR_W), .AW(2)) u_store (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_acc && mr_hit),
        .wr_addr (paddr[3:2]),
        .wr_data (pwdata[ADDR_W-1:0]),
        .a_addr  (paddr[3:2]),
        .a_data  (rd_a),
        .b_addr  (mr_sel),
        .b_data  (mr_word)
    );

    // Whole image goes out; only the bits that init or reserve force are patched
    always_comb begin
        mrs_word = mr_word;
        if (mr_sel == MR1_SEL && !done_q) begin
            mrs_word[MR1_DLL_OFF_BIT] = 1'b0;
        end
        if (mr_sel == MR0_SEL) begin
            mrs_word[MR0_RSV_HI:MR0_RSV_LO] = 2'h0;
            if (!done_q) begin
                mrs_word[MR0_DLL_RST_BIT] = 1'b1;
            end
        end
    end

    // ==================================================================
    // Sequencer
    always_comb begin
        state_d = state_q;
        seq_d   = seq_q;
        done_d  = done_q;
        cold_d  = cold_q;
        refuse  = 1'b0;
        cnt_d   = (cnt_q == '0) ? cnt_q : cnt_q - 1'b1;
        unique case (state_q)
            ST_IDLE, ST_READY: begin
                if (cold_go_q || warm_go_q) begin
                    state_d = ST_RST;
                    done_d  = 1'b0;
                    cold_d  = cold_go_q;
                    cnt_d   = cold_go_q ? CNT_W'(RST_PWR_CYC_P - 1)
                                        : CNT_W'(RST_WARM_CYC - 1);
                end else if (mrs_go_q) begin
                    if (state_q == ST_READY && bank_idle) begin
                        state_d = ST_PREP;
                    end else begin
                        refuse = 1'b1;
                    end
                end
            end
            ST_RST: begin
                if (cnt_q == '0) begin
                    state_d = ST_WAIT;
                    cnt_d   = CNT_W'(WAIT_LOAD - 1);
                end
            end
            ST_WAIT: begin
                if (cnt_q == '0) begin
                    state_d = ST_XPR;
                    seq_d   = 2'h0;
                    cnt_d   = CNT_W'(TXPR_CYC - 1);
                end
            end
            ST_XPR: begin
                if (cnt_q == '0) begin
                    state_d = ST_MRS;
                end
            end
            ST_MRS: begin
                state_d = ST_GAP;
                if (!done_q && seq_q != 2'h3) begin
                    cnt_d = CNT_W'(TMRD_TCK - 1);
                end else begin
                    cnt_d = CNT_W'(TMOD_TCK - 1);
                end
                if (!done_q) begin
                    seq_d = seq_q + 2'h1;
                end
            end
            ST_GAP: begin
                if (cnt_q == '0) begin
                    if (done_q) begin
                        state_d = ST_READY;
                    end else if (seq_q != 2'h0) begin
                        state_d = ST_MRS;
                    end else begin
                        state_d = ST_ZQ;
                    end
                end
            end
            ST_ZQ: begin
                state_d = ST_ZQW;
                cnt_d   = CNT_W'(ZQ_WAIT_CYC - 1);
            end
            ST_ZQW: begin
                if (cnt_q == '0) begin
                    state_d = ST_READY;
                    done_d  = 1'b1;
                end
            end
            ST_PREP: begin
                state_d = ST_MRS;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (busy && (cold_go_q || warm_go_q || mrs_go_q)) begin
            refuse = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            cnt_q   <= '0;
            seq_q   <= 2'h0;
            done_q  <= 1'b0;
            cold_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            seq_q   <= seq_d;
            done_q  <= done_d;
            cold_q  <= cold_d;
        end
    end

    // ==================================================================
    // DRAM pins, registered from the next state so they line up with state_q
    always_comb begin
        pin_d         = PINS_RST;
        pin_d.reset_n = 1'b1;
        pin_d.ck_en   = 1'b1;
        pin_d.cke     = 1'b1;
        pin_d.cmd     = CMD_NOP;
        unique case (state_d)
            ST_IDLE, ST_RST: begin
                pin_d = PINS_RST;
            end
            ST_WAIT: begin
                pin_d.cke = 1'b0;
            end
            ST_MRS: begin
                pin_d.cmd  = CMD_MRS;
                pin_d.ba   = {1'b0, mr_sel};
                pin_d.addr = mrs_word;
            end
            ST_ZQ: begin
                pin_d.cmd               = CMD_ZQCL;
                pin_d.addr[ZQ_LONG_BIT] = 1'b1;
            end
            ST_READY: begin
                pin_d.odt = odt_lvl_q;
            end
            default: begin
                pin_d.odt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dram_q <= PINS_RST;
        end else begin
            dram_q <= pin_d;
        end
    end

    // ==================================================================
    // APB slave: one wait state so the image store can answer reads
    always_comb begin
        hit    = 1'b1;
        rd_mux = 32'h0000_0000;
        if (mr_hit) begin
            rd_mux[ADDR_W-1:0] = rd_a;
        end else if (paddr == REG_CTRL) begin
            rd_mux[CTRL_MRSEL_LSB +: 2] = req_mr_q;
            rd_mux[CTRL_ODT_BIT]        = odt_lvl_q;
        end else if (paddr == REG_STATUS) begin
            rd_mux[STAT_BUSY_BIT]     = busy;
            rd_mux[STAT_DONE_BIT]     = done_q;
            rd_mux[STAT_ERR_BIT]      = err_q;
            rd_mux[STAT_ST_LSB +: 10] = state_q;
        end else begin
            hit = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q <= psel && penable && !pready_q;
            if (psel && penable && !pready_q) begin
                prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr_q <= !hit;
            end else begin
                pslverr_q <= 1'b0;
            end
        end
    end

    // Start and request bits act once and read back as zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cold_go_q <= 1'b0;
            warm_go_q <= 1'b0;
            mrs_go_q  <= 1'b0;
            req_mr_q  <= MRSEL_RST;
            odt_lvl_q <= ODT_RST;
        end else begin
            cold_go_q <= 1'b0;
            warm_go_q <= 1'b0;
            mrs_go_q  <= 1'b0;
            if (wr_acc && paddr == REG_CTRL) begin
                cold_go_q <= pwdata[CTRL_COLD_BIT];
                warm_go_q <= pwdata[CTRL_WARM_BIT];
                mrs_go_q  <= pwdata[CTRL_MRS_BIT];
                odt_lvl_q <= pwdata[CTRL_ODT_BIT];
                if (!busy) begin
                    req_mr_q <= pwdata[CTRL_MRSEL_LSB +: 2];
                end
            end
        end
    end

    // A refusal in the clearing cycle still sets the flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_q <= 1'b0;
        end else if (refuse) begin
            err_q <= 1'b1;
        end else if (wr_acc && paddr == REG_STATUS && pwdata[STAT_ERR_BIT]) begin
            err_q <= 1'b0;
        end
    end

    // ==================================================================
    // Checks
    logic [CNT_W-1:0] rst_low_cnt, rst_hi_cnt, ck_cnt, since_cke, since_mrs;
    logic [1:0]       mrs_n;
    logic             is_mrs, is_zq;

    assign is_mrs = dram_q.cmd == CMD_MRS;
    assign is_zq  = dram_q.cmd == CMD_ZQCL;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_low_cnt <= '0;
            rst_hi_cnt  <= '0;
            ck_cnt      <= '0;
            since_cke   <= '0;
            since_mrs   <= '0;
            mrs_n       <= 2'h0;
        end else begin
            rst_low_cnt <= dram_q.reset_n ? '0 : rst_low_cnt + CNT_W'(~&rst_low_cnt);
            rst_hi_cnt  <= !dram_q.reset_n ? '0 : rst_hi_cnt + CNT_W'(~&rst_hi_cnt);
            ck_cnt      <= !dram_q.ck_en ? '0 : ck_cnt + CNT_W'(~&ck_cnt);
            since_cke   <= !dram_q.cke ? '0 : since_cke + CNT_W'(~&since_cke);
            since_mrs   <= is_mrs ? CNT_W'(1) : since_mrs + CNT_W'(~&since_mrs);
            if (!dram_q.cke) begin
                mrs_n <= 2'h0;
            end else if (is_mrs && !done_q) begin
                mrs_n <= mrs_n + 2'h1;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_rst_cold_hold: assert property (
        $rose(dram_q.reset_n) && cold_q |-> rst_low_cnt >= RST_PWR_CYC_P)
        else $error("cold reset released too early");
    chk_rst_warm_hold: assert property (
        $rose(dram_q.reset_n) |-> rst_low_cnt >= RST_WARM_CYC)
        else $error("warm reset released too early");
    chk_cke_low_lead: assert property (
        $rose(dram_q.reset_n) |-> !dram_q.cke && $past(!dram_q.cke))
        else $error("cke not low before reset release");
    chk_cke_wait_time: assert property (
        $rose(dram_q.cke) |-> rst_hi_cnt >= CKE_WAIT_CYC_P)
        else $error("cke raised too soon after reset");
    chk_clock_stable: assert property (
        $rose(dram_q.cke) |-> ck_cnt >= CK_STABLE_CYC)
        else $error("clock not stable before cke");
    chk_nop_before_cke: assert property (
        $rose(dram_q.cke) |-> $past(dram_q.cmd) == CMD_NOP)
        else $error("no nop before cke rose");
    chk_cke_held_high: assert property (
        $fell(dram_q.cke) |-> $past(state_q) == ST_IDLE || $past(state_q) == ST_READY)
        else $error("cke dropped during init");
    chk_odt_static_low: assert property (
        dram_q.cke && state_q != ST_READY |-> !dram_q.odt)
        else $error("odt not low while busy");
    chk_xpr_before_mrs: assert property (
        is_mrs && !done_q |-> since_cke >= TXPR_CYC)
        else $error("mrs before txpr");
    chk_mrs_init_order: assert property (
        is_mrs && !done_q |-> dram_q.ba == {1'b0, init_mr(mrs_n)})
        else $error("mode registers loaded out of order");
    chk_mr_dll_bits: assert property (
        is_mrs && !done_q |-> (dram_q.ba != 3'h1 || !dram_q.addr[MR1_DLL_OFF_BIT])
                           && (dram_q.ba != 3'h0 || dram_q.addr[MR0_DLL_RST_BIT]))
        else $error("dll enable or reset bit wrong");
    chk_only_nop_gaps: assert property (
        dram_q.cke && !done_q && !is_mrs && !is_zq |-> dram_q.cmd == CMD_NOP)
        else $error("non-nop command during init");
    chk_mrd_spacing: assert property (
        is_mrs |=> !is_mrs [*3])
        else $error("mrs commands too close");
    chk_mod_spacing: assert property (
        is_zq |-> since_mrs >= TMOD_TCK)
        else $error("command too soon after mrs");
    chk_idle_rewrite: assert property (
        is_mrs && done_q |-> $past(bank_idle, 2))
        else $error("runtime mrs while not idle");
    chk_odt_after_mod: assert property (
        $rose(dram_q.odt) |-> since_mrs >= TMOD_TCK)
        else $error("odt raised within tmod");
    chk_mr0_reserved: assert property (
        is_mrs && dram_q.ba[1:0] == MR0_SEL |-> dram_q.addr[MR0_RSV_HI:MR0_RSV_LO] == 2'h0
                                              && !dram_q.ba[2])
        else $error("mr0 reserved bits set");

    cov_init_done:   cover property ($rose(done_q) && cold_q);
    cov_warm_done:   cover property ($rose(done_q) && !cold_q);
    cov_runtime_mrs: cover property (is_mrs && done_q);
    cov_refused:     cover property (refuse);

endmodule // ddr_init_ctrl

// ===== pkg/ddr_init_pkg.sv
// Purpose: Shared constants, pin bundle and state codes for the DDR3 init controller.
// Assumes: pclk at 100 MHz; every timing count rounds up to whole cycles.
// Notes:   tXS, tMRD, tMOD, tDLLK and tZQinit are plain defaults; set them per speed bin.
package ddr_init_pkg;

    // ==================================================================
    // Clock and timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int T_RST_PWR_US   = 200;
    localparam int RST_PWR_CYC    = (T_RST_PWR_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_RST_WARM_NS  = 100;
    localparam int RST_WARM_CYC   = (T_RST_WARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_CKE_RST_NS   = 10;
    localparam int CKE_RST_CYC    = (T_CKE_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_CKE_WAIT_US  = 500;
    localparam int CKE_WAIT_CYC   = (T_CKE_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_CK_STABLE_NS = 10;
    localparam int CK_STABLE_TCK  = 5;
    localparam int CK_STABLE_NSC  = (T_CK_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CK_STABLE_CYC  = (CK_STABLE_NSC > CK_STABLE_TCK) ? CK_STABLE_NSC
                                                                    : CK_STABLE_TCK;
    localparam int T_XS_NS        = 200;
    localparam int TXPR_TCK_MIN   = 5;
    localparam int TXS_CYC        = (T_XS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TXPR_CYC       = (TXS_CYC > TXPR_TCK_MIN) ? TXS_CYC : TXPR_TCK_MIN;
    localparam int TMRD_TCK       = 4;
    localparam int TMOD_TCK       = 12;
    localparam int TDLLK_TCK      = 512;
    localparam int TZQINIT_TCK    = 512;
    localparam int ZQ_WAIT_CYC    = (TDLLK_TCK > TZQINIT_TCK) ? TDLLK_TCK : TZQINIT_TCK;
    localparam int CNT_W          = 17;

    // ==================================================================
    // Register map and fields
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_MR0    = 12'h010;
    localparam logic [11:0] REG_MR1    = 12'h014;
    localparam logic [11:0] REG_MR2    = 12'h018;
    localparam logic [11:0] REG_MR3    = 12'h01c;
    localparam int CTRL_COLD_BIT  = 0;
    localparam int CTRL_WARM_BIT  = 1;
    localparam int CTRL_MRS_BIT   = 2;
    localparam int CTRL_MRSEL_LSB = 4;
    localparam int CTRL_ODT_BIT   = 8;
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_DONE_BIT  = 1;
    localparam int STAT_ERR_BIT   = 2;
    localparam int STAT_ST_LSB    = 16;
    localparam logic [1:0] MRSEL_RST = 2'h0;
    localparam logic       ODT_RST   = 1'b0;

    // ==================================================================
    // DRAM command and address
    localparam int ADDR_W = 15;
    localparam logic [3:0] CMD_DES  = 4'hf;
    localparam logic [3:0] CMD_NOP  = 4'h7;
    localparam logic [3:0] CMD_MRS  = 4'h0;
    localparam logic [3:0] CMD_ZQCL = 4'h6;
    localparam int ZQ_LONG_BIT     = 10;
    localparam int MR1_DLL_OFF_BIT = 0;
    localparam int MR0_DLL_RST_BIT = 8;
    localparam int MR0_RSV_LO      = 13;
    localparam int MR0_RSV_HI      = 14;
    localparam logic [1:0] MR0_SEL = 2'h0;
    localparam logic [1:0] MR1_SEL = 2'h1;
    localparam logic [1:0] MR2_SEL = 2'h2;
    localparam logic [1:0] MR3_SEL = 2'h3;

    typedef struct packed {
        logic              reset_n;
        logic              ck_en;
        logic              cke;
        logic              odt;
        logic [3:0]        cmd;   // {cs_n, ras_n, cas_n, we_n}
        logic [2:0]        ba;
        logic [ADDR_W-1:0] addr;
    } dram_pins_s;

    localparam dram_pins_s PINS_RST = '{reset_n: 1'b0, ck_en: 1'b0, cke: 1'b0, odt: 1'b0,
                                        cmd: CMD_DES, ba: 3'h0, addr: 15'h0000};

    typedef enum logic [9:0] {
        ST_IDLE  = 10'h001,
        ST_RST   = 10'h002,
        ST_WAIT  = 10'h004,
        ST_XPR   = 10'h008,
        ST_MRS   = 10'h010,
        ST_GAP   = 10'h020,
        ST_ZQ    = 10'h040,
        ST_ZQW   = 10'h080,
        ST_READY = 10'h100,
        ST_PREP  = 10'h200
    } state_e;

    // Load order of the mode registers during init
    function automatic logic [1:0] init_mr(input logic [1:0] seq);
        unique case (seq)
            2'h0: init_mr = MR2_SEL;
            2'h1: init_mr = MR3_SEL;
            2'h2: init_mr = MR1_SEL;
            2'h3: init_mr = MR0_SEL;
        endcase
    endfunction

endpackage

// ===== rtl/mr_store.sv
// Purpose: Four-word store for the mode register images, two registered read ports.
// Assumes: One write port; reads return the word one clock after the address.
// Notes:   Words clear to zero so an unwritten image is defined.
module mr_store #(
    parameter int DW = 15,
    parameter int AW = 2
) (
    // Clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // Write port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    // Read ports
    input  wire logic [AW-1:0] a_addr,
    output logic      [DW-1:0] a_data,
    input  wire logic [AW-1:0] b_addr,
    output logic      [DW-1:0] b_data
);

    logic [DW-1:0] mem [2**AW];

    // ==================================================================
    // Storage
    for (genvar i = 0; i < 2**AW; i++) begin : g_word
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                mem[i] <= '0;
            end else if (wr_en && wr_addr == AW'(i)) begin
                mem[i] <= wr_data;
            end
        end
    end

    // ==================================================================
    // Registered reads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_data <= '0;
            b_data <= '0;
        end else begin
            a_data <= mem[a_addr];
            b_data <= mem[b_addr];
        end
    end

endmodule // mr_store

// ===== tb/dram_model.sv
// Purpose: Behavioural DDR3 device seen from its pins.
// Assumes: Pins change only at rising pclk edges.
// Notes:   viol flags tMRD, tMOD and bank faults; sticky until reset.
module dram_model
    import ddr_init_pkg::*;
(
    input  wire logic                     pclk,
    input  wire ddr_init_pkg::dram_pins_s dram,
    output logic [3:0][14:0]              mr,
    output logic [7:0]                    seq,
    output logic                          viol,
    output logic                          rtt_on
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] gap_q;
    logic       mrs;
    logic       oth;
    assign mrs = dram.cke && dram.cmd == CMD_MRS;
    assign oth = dram.cke && !mrs && dram.cmd != CMD_NOP && dram.cmd != CMD_DES;
    // Termination stays off in reset and until CKE is registered high
    always_ff @(posedge pclk) rtt_on <= dram.reset_n & dram.cke & dram.odt;
    always_ff @(posedge pclk) begin
        if (!dram.reset_n) begin
            mr    <= 'x;
            seq   <= 8'h00;
            gap_q <= 8'hff;
            viol  <= 1'h0;
        end else begin
            gap_q <= mrs ? 8'h00 : gap_q + {7'h0, gap_q != 8'hff};
            if ((mrs && gap_q < TMRD_TCK - 1) || (oth && gap_q < TMOD_TCK - 1) || (mrs && dram.ba[2]))
                viol <= 1'h1;
            if (mrs) begin
                // Only the mode word changes; the array is never touched
                mr[dram.ba[1:0]] <= dram.addr;
                seq              <= {seq[5:0], dram.ba[1:0]};
            end
        end
    end
endmodule // dram_model

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the DDR3 init controller.
// Assumes: Shortened reset counts; far side is dram_model.
// Notes:   Status is polled over APB under a bounded count.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ddr_init_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, bank_idle = 1;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, e, viol, rtt_on;
    logic [3:0][14:0] mr;
    logic [7:0] seq;
    dram_pins_s dram;
    int err_count, samples_checked;
    always #5 pclk = ~pclk;
    ddr_init_ctrl #(.RST_PWR_CYC_P(30), .CKE_WAIT_CYC_P(20)) i_ddr_init_ctrl (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .bank_idle, .dram);
    dram_model i_dram_model (.pclk, .dram, .mr, .seq, .viol, .rtt_on);
    task automatic chk(input string n, input logic [31:0] s, x);
        samples_checked++;
        if (s !== x) begin
            err_count++;
            $display("BAD %s exp %h seen %h", n, x, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        rd = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            apb(1'h0, REG_STATUS, '0);
            n++;
        end while (rd[1:0] !== 2'h2 && n < 3000);
        if (rd[1:0] !== 2'h2) err_count++;
    endtask
    task automatic t_regs();
        apb(1'h1, REG_MR0, 32'h7e35);
        apb(1'h1, REG_MR1, 32'h3);
        apb(1'h1, REG_MR2, 32'h18);
        apb(1'h1, REG_MR3, 32'h4);
        apb(1'h0, REG_MR0, '0);
        chk("mr0 image", rd, 32'h7e35);
        apb(1'h0, 12'h020, '0);
        chk("unmapped", {31'h0, e}, 32'h1);
    endtask
    task automatic t_cold();
        apb(1'h1, REG_CTRL, 32'h1);
        wait_ready();
        chk("status", rd, 32'h0100_0002);
        chk("order", seq, 32'hb4);
        chk("mr2", mr[2], 32'h18);
        chk("mr3", mr[3], 32'h4);
        chk("mr1", mr[1], 32'h2);
        chk("mr0", mr[0], 32'h1f35);
        chk("spacing", viol, 32'h0);
    endtask
    task automatic t_runtime();
        apb(1'h1, REG_MR2, 32'h10);
        apb(1'h1, REG_CTRL, 32'h124);
        wait_ready();
        chk("rt mr2", mr[2], 32'h10);
        chk("rt seq", seq, 32'hd2);
        chk("rt tmod", viol, 32'h0);
        chk("rt odt", {30'h0, dram.odt, rtt_on}, 32'h3);
        apb(1'h0, REG_CTRL, '0);
        chk("ctrl", rd, 32'h120);
    endtask
    task automatic t_refused();
        bank_idle <= 1'h0;
        apb(1'h1, REG_MR3, 32'h6);
        apb(1'h1, REG_CTRL, 32'h34);
        apb(1'h0, REG_STATUS, '0);
        chk("refused", rd, 32'h0100_0006);
        chk("mr3 kept", mr[3], 32'h4);
        bank_idle <= 1'h1;
        apb(1'h1, REG_STATUS, 32'h4);
        apb(1'h0, REG_STATUS, '0);
        chk("err clear", rd, 32'h0100_0002);
    endtask
    task automatic t_warm();
        apb(1'h1, REG_CTRL, 32'h2);
        wait_ready();
        chk("warm seq", seq, 32'hb4);
        chk("warm mr3", mr[3], 32'h6);
        chk("warm gap", viol, 32'h0);
    endtask
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #500000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        t_regs();
        t_cold();
        t_runtime();
        t_refused();
        t_warm();
        tally_and_finish();
    end
endmodule // testbench
